// ===== design/flash_protect_cmd_map.svh
// Register offsets, field positions, reset values and fixed addresses
// Assumes inclusion by the flash protection and command object block
`ifndef FLASH_PROTECT_CMD_MAP_SVH
`define FLASH_PROTECT_CMD_MAP_SVH

// ==========================================
// Register byte offsets
`define OFS_PFLASH_PROT 8'h00
`define OFS_DFLASH_PROT 8'h04
`define OFS_COB_INDEX 8'h08
`define OFS_COB_ARRAY 8'h0C
`define OFS_FLASH_STATUS 8'h10
`define OFS_FACTORY_ZERO 8'h14

// ==========================================
// Field positions and command object word count
`define PF_OPEN_BIT 7
`define PF_HDIS_BIT 5
`define PF_LDIS_BIT 2
`define DF_DISABLE_BIT 7
`define ST_COMPLETE_BIT 7
`define ST_VIOLATION_BIT 4
`define COB_WORDS 6

// ==========================================
// Reset values: fully protected until the configuration bytes arrive
`define PF_PROT_RESET 8'h7F
`define DF_PROT_RESET 8'h1F
`define DF_PROT_MASK 8'h9F

// ==========================================
// Fixed global addresses
`define CFG_PF_PROT_ADDR 23'h7F_FF0C
`define CFG_DF_PROT_ADDR 23'h7F_FF0D
`define DF_BASE_ADDR 23'h10_0000
`define PF_TOP_BITS 5'h1F
`define PF_HIGH_TOP 9'h1FF
`define PF_LOW_TOP 10'h3FC

`endif

// ===== design/flash_protect_cmd_object.sv
// Flash protection checker and indexed command object array behind an APB slave
// Assumes an APB master on core_clk and a memory controller that runs commands
//
// The implementer's own choices: the APB slave port and the address map.
`include "flash_protect_cmd_map.svh"
`timescale 1ns/100ps
`default_nettype none

module flash_protect_cmd_object #(
	parameter logic [7:0] CMD_PF_ERASE_BLOCK = 8'h01,
	parameter logic [7:0] CMD_PF_ERASE_SECTOR = 8'h02,
	parameter logic [7:0] CMD_PF_PROGRAM = 8'h03,
	parameter logic [7:0] CMD_DF_ERASE_BLOCK = 8'h04,
	parameter logic [7:0] CMD_DF_ERASE_SECTOR = 8'h05,
	parameter logic [7:0] CMD_DF_PROGRAM = 8'h06
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire flash_protect_cmd_pkg::nvm_cfg_type nvm_cfg,
	output flash_protect_cmd_pkg::cmd_fields_type cmd_fields,
	output logic cmd_start,
	input wire logic cmd_done,
	input wire flash_protect_cmd_pkg::cmd_ret_type cmd_ret
);

	// ==========================================
	// Helpers
	function automatic logic scenario_ok(input logic [2:0] from, input logic [2:0] to);
		logic [7:0] allowed;
		allowed = 8'h00;
		unique case (from)
			3'd0: allowed = 8'h0F;
			3'd1: allowed = 8'h0A;
			3'd2: allowed = 8'h0C;
			3'd3: allowed = 8'h08;
			3'd4: allowed = 8'h18;
			3'd5: allowed = 8'h3C;
			3'd6: allowed = 8'h5A;
			3'd7: allowed = 8'hFF;
		endcase
		return allowed[to];
	endfunction : scenario_ok

	function automatic logic [2:0] scenario_of(input logic [7:0] prot);
		return {prot[`PF_OPEN_BIT], prot[`PF_HDIS_BIT], prot[`PF_LDIS_BIT]};
	endfunction : scenario_of

	function automatic logic [15:0] byte_merge(input logic [15:0] old,
		input logic [15:0] wdata, input logic [1:0] strb);
		return {strb[1] ? wdata[15:8] : old[15:8], strb[0] ? wdata[7:0] : old[7:0]};
	endfunction : byte_merge

	// ==========================================
	// State
	logic [7:0] pf_prot_reg;
	logic [7:0] df_prot_reg;
	logic [2:0] cob_index_reg;
	logic [15:0] cob_reg [`COB_WORDS];
	logic complete_reg;
	logic violation_reg;
	logic start_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	// ==========================================
	// Bus decode
	wire logic setup_phase = psel & ~penable;
	wire logic bus_write = psel & penable & pready_reg & pwrite;
	wire logic hit_pf = (paddr == `OFS_PFLASH_PROT);
	wire logic hit_df = (paddr == `OFS_DFLASH_PROT);
	wire logic hit_idx = (paddr == `OFS_COB_INDEX);
	wire logic hit_cob = (paddr == `OFS_COB_ARRAY);
	wire logic hit_st = (paddr == `OFS_FLASH_STATUS);
	wire logic hit_fz = (paddr == `OFS_FACTORY_ZERO);
	wire logic mapped = hit_pf | hit_df | hit_idx | hit_cob | hit_st | hit_fz;
	wire logic idx_valid = (cob_index_reg < 3'(`COB_WORDS));
	wire logic [15:0] cob_read = idx_valid ? cob_reg[cob_index_reg] : 16'h0000;

	wire logic [31:0] read_mux =
		hit_pf ? {24'h00_0000, pf_prot_reg} :
		hit_df ? {24'h00_0000, df_prot_reg} :
		hit_idx ? {29'h0000_0000, cob_index_reg} :
		hit_cob ? {16'h0000, cob_read} :
		hit_st ? {24'h00_0000, complete_reg, 2'b00, violation_reg, 4'h0} :
		32'h0000_0000;

	// ==========================================
	// Program-flash protection write check
	wire logic [7:0] pf_wr = pwdata[7:0];
	wire logic pf_hdis = pf_prot_reg[`PF_HDIS_BIT];
	wire logic pf_ldis = pf_prot_reg[`PF_LDIS_BIT];
	wire logic [1:0] pf_hs = pf_prot_reg[4:3];
	wire logic [1:0] pf_ls = pf_prot_reg[1:0];
	wire logic [7:0] pf_candidate = {pf_wr[7], pf_prot_reg[6], pf_wr[5],
		pf_hdis ? pf_wr[4:3] : pf_hs,
		pf_wr[2],
		pf_ldis ? pf_wr[1:0] : pf_ls};
	wire logic pf_accept = scenario_ok(scenario_of(pf_prot_reg),
		scenario_of(pf_candidate));

	// ==========================================
	// Data-flash protection write check
	wire logic [4:0] df_size = df_prot_reg[4:0];
	wire logic df_open = df_prot_reg[`DF_DISABLE_BIT];
	wire logic df_accept = (pwdata[`DF_DISABLE_BIT] <= df_open)
		& (pwdata[4:0] >= df_size);
	wire logic [7:0] df_candidate = pwdata[7:0] & `DF_PROT_MASK;

	// ==========================================
	// Command classification and protection lookup
	wire logic [7:0] code = cob_reg[0][15:8];
	wire logic [22:0] addr = {cob_reg[0][6:0], cob_reg[1]};
	wire logic [22:0] df_offset = addr - `DF_BASE_ADDR;
	wire logic df_in = (addr >= `DF_BASE_ADDR) & (df_offset[22:8] <= {10'h000, df_size});
	wire logic df_protected = ~df_open & df_in;
	wire logic df_any = ~df_open;
	wire logic pf_in = (addr[22:18] == `PF_TOP_BITS);
	wire logic hi_in = (addr[22:14] == `PF_HIGH_TOP) & (addr[13:11] >= 3'(3'b111 << pf_hs));
	wire logic lo_in = (addr[22:13] == `PF_LOW_TOP)
		& ({1'b0, addr[12:10]} < 4'(4'd1 << pf_ls));
	wire logic pf_ranges = (~pf_hdis & hi_in) | (~pf_ldis & lo_in);
	wire logic pf_open = pf_prot_reg[`PF_OPEN_BIT];
	wire logic pf_protected = pf_in & (pf_open ? pf_ranges : ~pf_ranges);
	wire logic pf_any = pf_open ? (~pf_hdis | ~pf_ldis) : 1'b1;
	wire logic cmd_violates =
		((code == CMD_DF_PROGRAM) | (code == CMD_DF_ERASE_SECTOR)) & df_protected |
		(code == CMD_DF_ERASE_BLOCK) & df_any |
		((code == CMD_PF_PROGRAM) | (code == CMD_PF_ERASE_SECTOR)) & pf_protected |
		(code == CMD_PF_ERASE_BLOCK) & pf_any;

	// ==========================================
	// Command launch and completion
	wire logic st_write = bus_write & hit_st & pstrb[0];
	wire logic launch_req = st_write & pwdata[`ST_COMPLETE_BIT] & complete_reg
		& ~violation_reg;
	wire logic launch = launch_req & ~cmd_violates;
	wire logic violation_set = launch_req & cmd_violates;
	wire logic violation_clr = st_write & pwdata[`ST_VIOLATION_BIT];
	wire logic cob_write = bus_write & hit_cob & complete_reg & idx_valid;
	wire logic ret_write = cmd_ret.wr & ~complete_reg
		& (cmd_ret.index < 3'(`COB_WORDS));

	// ==========================================
	// APB answer: captured in setup, completes on the first access edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg <= setup_phase ? read_mux : 32'h0000_0000;
			pready_reg <= setup_phase;
			pslverr_reg <= setup_phase & ~mapped;
		end
	end

	// ==========================================
	// Protection registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pf_prot_reg <= `PF_PROT_RESET;
			df_prot_reg <= `DF_PROT_RESET;
		end else if (nvm_cfg.load) begin
			pf_prot_reg <= nvm_cfg.pf_fault ? `PF_PROT_RESET : nvm_cfg.pf_byte;
			df_prot_reg <= nvm_cfg.df_fault ? `DF_PROT_RESET
				: (nvm_cfg.df_byte & `DF_PROT_MASK);
		end else begin
			if (bus_write & hit_pf & pstrb[0] & pf_accept)
				pf_prot_reg <= pf_candidate;
			if (bus_write & hit_df & pstrb[0] & df_accept)
				df_prot_reg <= df_candidate;
		end
	end

	// ==========================================
	// Index register and status flags
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cob_index_reg <= 3'd0;
			complete_reg <= 1'b1;
			violation_reg <= 1'b0;
			start_reg <= 1'b0;
		end else begin
			if (bus_write & hit_idx & pstrb[0])
				cob_index_reg <= pwdata[2:0];
			if (launch)
				complete_reg <= 1'b0;
			else if (cmd_done & ~complete_reg)
				complete_reg <= 1'b1;
			if (violation_set)
				violation_reg <= 1'b1;
			else if (violation_clr)
				violation_reg <= 1'b0;
			start_reg <= launch;
		end
	end

	// ==========================================
	// Command object array
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `COB_WORDS; i++) begin
				cob_reg[i] <= 16'h0000;
			end
		end else if (cob_write) begin
			cob_reg[cob_index_reg] <= byte_merge(cob_reg[cob_index_reg],
				(cob_index_reg == 3'd0) ? (pwdata[15:0] & 16'hFF7F) : pwdata[15:0],
				pstrb[1:0]);
		end else if (ret_write) begin
			cob_reg[cmd_ret.index] <= cmd_ret.data;
		end
	end

	// ==========================================
	// Outputs
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign cmd_start = start_reg;
	assign cmd_fields = {cob_reg[0][15:8], cob_reg[0][6:0], cob_reg[1],
		cob_reg[2], cob_reg[3], cob_reg[4], cob_reg[5]};

endmodule : flash_protect_cmd_object

`default_nettype wire

// ===== design/flash_protect_cmd_pkg.sv
// Types shared by the flash protection and command object block
// Assumes the map header for all numeric constants
package flash_protect_cmd_pkg;

	// ==========================================
	// Configuration bytes fetched from flash during the reset sequence
	typedef struct packed {
		logic load;
		logic pf_fault;
		logic [7:0] pf_byte;
		logic df_fault;
		logic [7:0] df_byte;
	} nvm_cfg_type;

	// ==========================================
	// Command fields handed to the memory controller
	typedef struct packed {
		logic [7:0] code;
		logic [22:0] addr;
		logic [15:0] data0;
		logic [15:0] data1;
		logic [15:0] data2;
		logic [15:0] data3;
	} cmd_fields_type;

	// ==========================================
	// Result word written back by the memory controller
	typedef struct packed {
		logic wr;
		logic [2:0] index;
		logic [15:0] data;
	} cmd_ret_type;

endpackage : flash_protect_cmd_pkg

// ===== sim/flash_protect_cmd_object_test.sv
// Self-checking bench for the flash protection and command object block
// Assumes package, map header and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module flash_protect_cmd_object_test;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	flash_protect_cmd_pkg::nvm_cfg_type nvm_cfg = '0;
	flash_protect_cmd_pkg::cmd_fields_type cmd_fields;
	flash_protect_cmd_pkg::cmd_ret_type cmd_ret = '0;
	logic cmd_start;
	logic cmd_done = 1'b0;
	logic [31:0] seed = 32'h6289_60ee;
	logic [31:0] rd;
	logic err;
	logic [15:0] w [8];
	logic [7:0] a;
	int fail_count = 0;
	int comparisons = 0;
	int starts = 0;
	logic [7:0] allow [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) if (cmd_start === 1'b1) starts++;
	flash_protect_cmd_object flash_protect_cmd_object_inst (.core_clk(core_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nvm_cfg(nvm_cfg),
		.cmd_fields(cmd_fields), .cmd_start(cmd_start), .cmd_done(cmd_done), .cmd_ret(cmd_ret));
	// ====
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [7:0] scen(int s);
		return {s[2], 1'b0, s[1], 2'b11, s[0], 2'b11};
	endfunction : scen
	// Whole write dropped unless disable only falls and size does not shrink
	function automatic logic [7:0] dfexp(logic [7:0] o, logic [7:0] n);
		return (n[7] <= o[7] && n[4:0] >= o[4:0]) ? (n & 8'h9F) : o;
	endfunction : dfexp
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic apb(input logic wt, input logic [7:0] ad, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wt;
		paddr <= ad;
		pwdata <= d;
		pstrb <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			chk("pready", 1, 32'(pready));
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] ad, input logic [15:0] d, input logic [3:0] s);
		apb(1'b1, ad, {16'h0000, d}, s);
	endtask : wr
	task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e);
		apb(1'b0, ad, '0, 4'h0);
		chk($sformatf("reg %h", ad), e, rd);
	endtask : rd_chk
	task automatic boot(input logic [7:0] pf, input logic [7:0] df, input logic flt, input logic ld);
		rst_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		nvm_cfg <= '{ld, flt, pf, flt, df};
		@(posedge core_clk);
		nvm_cfg <= '0;
	endtask : boot
	task automatic cmd(input logic [7:0] c, input logic [22:0] ad);
		wr(8'h08, 16'h0000, 4'h1);
		wr(8'h0C, {c, 1'b0, ad[22:16]}, 4'h3);
		wr(8'h08, 16'h0001, 4'h1);
		wr(8'h0C, ad[15:0], 4'h3);
		wr(8'h10, 16'h0080, 4'h1);
	endtask : cmd
	task automatic finish_cmd(input logic [15:0] v);
		cmd_ret <= '{1'b1, 3'h2, v};
		@(posedge core_clk);
		cmd_ret <= '0;
		cmd_done <= 1'b1;
		@(posedge core_clk);
		cmd_done <= 1'b0;
	endtask : finish_cmd
	// ====
	// Scenarios
	initial begin
		boot(8'h00, 8'h00, 1'b0, 1'b0);
		rd_chk(8'h00, 32'h0000_007F);
		rd_chk(8'h04, 32'h0000_001F);
		rd_chk(8'h10, 32'h0000_0080);
		boot(8'hBF, 8'h80, 1'b1, 1'b1);
		rd_chk(8'h00, 32'h0000_007F);
		rd_chk(8'h04, 32'h0000_001F);
		wr(8'h14, 16'hFFFF, 4'hF);
		rd_chk(8'h14, 32'h0000_0000);
		rd_chk(8'h18, 32'h0000_0000);
		chk("unmapped err", 32'h0000_0001, 32'(err));
		$display("done: reset");
		for (int f = 0; f < 8; f++) begin
			for (int t = 0; t < 8; t++) begin
				boot(scen(f), 8'h80, 1'b0, 1'b1);
				wr(8'h00, 16'(scen(t)), 4'h1);
				rd_chk(8'h00, 32'(allow[f][t] ? scen(t) : scen(f)));
			end
		end
		boot(8'h9B, 8'h80, 1'b0, 1'b1);
		wr(8'h00, 16'h0080, 4'h1);
		rd_chk(8'h00, 32'h0000_009B);
		$display("done: pflash");
		repeat (24) begin
			a = 8'(rnd()) & 8'h9F;
			boot(8'hBF, a, 1'b0, 1'b1);
			rd_chk(8'h04, 32'(a));
			w[0] = 16'(rnd());
			wr(8'h04, w[0], 4'h1);
			rd_chk(8'h04, 32'(dfexp(a, w[0][7:0])));
		end
		$display("done: dflash");
		for (int i = 0; i < 16; i++) begin
			if (i < 8) w[i] = 16'(rnd());
			wr(8'h08, 16'(i % 8), 4'h1);
			if (i < 8) wr(8'h0C, w[i], 4'h3);
			else rd_chk(8'h0C, i > 13 ? '0 : 32'(i == 8 ? w[0] & 16'hFF7F : w[i - 8]));
		end
		chk("code", 32'(w[0][15:8]), 32'(cmd_fields.code));
		chk("addr", 32'({w[0][6:0], w[1]}), 32'(cmd_fields.addr));
		chk("data1", 32'(w[3]), 32'(cmd_fields.data1));
		wr(8'h08, 16'h0002, 4'h1);
		wr(8'h0C, 16'h5AA5, 4'h2);
		rd_chk(8'h0C, 32'({8'h5A, w[2][7:0]}));
		// Data flash left open so the launch does not depend on the random state
		boot(8'hBF, 8'h80, 1'b0, 1'b1);
		cmd(8'h06, 23'h10_0010);
		rd_chk(8'h10, 32'h0000_0000);
		wr(8'h0C, 16'h1234, 4'h3);
		finish_cmd(16'hBEEF);
		rd_chk(8'h10, 32'h0000_0080);
		rd_chk(8'h0C, 32'h0000_0010);
		wr(8'h08, 16'h0002, 4'h1);
		rd_chk(8'h0C, 32'h0000_BEEF);
		boot(8'hBF, 8'h00, 1'b0, 1'b1);
		cmd(8'h06, 23'h10_00FF);
		rd_chk(8'h10, 32'h0000_0090);
		wr(8'h10, 16'h0010, 4'h1);
		cmd(8'h06, 23'h10_0100);
		rd_chk(8'h10, 32'h0000_0000);
		finish_cmd(16'h0000);
		cmd(8'h04, 23'h10_0100);
		rd_chk(8'h10, 32'h0000_0090);
		boot(8'h7F, 8'h9F, 1'b0, 1'b1);
		cmd(8'h03, 23'h7F_0000);
		rd_chk(8'h10, 32'h0000_0090);
		wr(8'h10, 16'h0010, 4'h1);
		cmd(8'h04, 23'h10_0000);
		rd_chk(8'h10, 32'h0000_0000);
		finish_cmd(16'h0000);
		chk("starts", 32'h0000_0003, 32'(starts));
		$display("done: commands");
		conclude();
	end
endmodule : flash_protect_cmd_object_test
`default_nettype wire

// ===== sim/flash_protect_cmd_sva.sv
// Port checker for the flash protection and command object block
// Assumes one clock domain and a bind onto the design top module
`timescale 1ns/100ps
`default_nettype none
module flash_protect_cmd_sva (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire flash_protect_cmd_pkg::cmd_fields_type cmd_fields,
	input wire logic cmd_start,
	input wire logic cmd_done,
	input wire flash_protect_cmd_pkg::cmd_ret_type cmd_ret
);
	// ====
	// Command in flight, from start pulse to done
	logic busy_reg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) busy_reg <= 1'b0;
		else if (cmd_start) busy_reg <= 1'b1;
		else if (cmd_done) busy_reg <= 1'b0;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_err_unmapped: assert property (psel && !penable |=> pslverr == $past(paddr > 8'h14))
		else $error("wrong slave error");
	a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside access");
	a_factory_zero: assert property (psel && !penable && !pwrite && paddr == 8'h14 |=> prdata == 0)
		else $error("reserved register not zero");
	a_start_launch: assert property (cmd_start |-> $past(psel && penable && pwrite && paddr == 8'h10 && pwdata[7]))
		else $error("start without launch");
	a_no_start_busy: assert property (busy_reg |-> !cmd_start)
		else $error("start while busy");
	a_fields_locked: assert property (busy_reg && !cmd_ret.wr |=> $stable(cmd_fields))
		else $error("fields moved while busy");
	cover property (cmd_start);
	cover property (pslverr);
	cover property (busy_reg && cmd_done);
endmodule : flash_protect_cmd_sva
bind flash_protect_cmd_object flash_protect_cmd_sva flash_protect_cmd_sva_inst (
	.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.cmd_fields(cmd_fields), .cmd_start(cmd_start), .cmd_done(cmd_done), .cmd_ret(cmd_ret));
`default_nettype wire
